/* hdl/tmr_elapsed.sv */
// counts ticks that pass between two executions of one timer
// assumes take is a one-cycle pulse; the count saturates
`timescale 1ns/100ps

module tmr_elapsed import tmr_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic take,
  output logic [ELAPSED_W-1:0] count
);

  // R24 tick seen in the taking cycle starts the next span
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (take) begin
      count <= {{(ELAPSED_W-1){1'b0}}, tick};
    end else if (tick && !(&count)) begin
      count <= count + 1'b1;
    end
  end

endmodule

/* hdl/tmr_pkg.sv */
// constants, carriers and BCD helpers shared by the timer block
// assumes one 50 MHz clock and control bits from same-clock scan logic
//
// How it works
// R01 - down timer input low reloads set value
// R02 - input high counts down, done at zero
// R03 - timed out holds until relaunch or rewrite
// R04 - set value range BCD 9.999 s, binary 65.535 s
// R05 - timeout at most one millisecond early
// R06 - error flag only for bad BCD set value
// R07 - execution refreshes value and done flag
// R08 - done flag may lag one scan
// R09 - mode change clears unless hold bit set
// R10 - power reset leaves value zero, done clear
// R11 - reset command loads all nines or ones
// R12 - interlock reloads down timer, clears done
// R13 - jumped section keeps value and flag
// R14 - forcing down timer: set zeroes, reset reloads
// R15 - accumulator counts tenths while input high
// R16 - accumulator reset clears value and flag
// R17 - interlock keeps accumulator state unchanged
// R18 - accumulator forcing zeroes value, overrides inputs
// R19 - scan must not exceed 100 ms
// R20 - user picks slot and legal set value
// R21 - shared slots must not run together
// R22 - down timer counts one millisecond per step
// R23 - down timer slot limited to 0..15
// R24 - derive 1 ms and 100 ms ticks
// R25 - binary variants never raise error flag

package tmr_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MS_TICK_NS = 1_000_000;
  localparam int unsigned MS_TICK_CYC = MS_TICK_NS / CLK_NS;
  localparam int unsigned SLOW_TICK_MS = 100;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned SLOW_W = 7;
  localparam int unsigned ELAPSED_W = 8;
  localparam logic [15:0] PV_RESET = 16'h0000;
  localparam logic [15:0] BCD_FULL = 16'h9999;
  localparam logic [15:0] BIN_FULL = 16'hFFFF;

  typedef logic [15:0] tmr_word_t;

  // one timer's command bits as the scan engine presents them
  typedef struct packed {
    logic exec;
    logic timer_in;
    logic bcd_mode;
    logic force_set;
    logic force_reset;
    logic interlock;
    logic jump;
    logic reset_cmd;
    logic reset_in;
  } tmr_ctl_s;

  function automatic logic tmr_bcd_ok(input tmr_word_t w);
    return (w[15:12] < 4'hA) && (w[11:8] < 4'hA) &&
           (w[7:4] < 4'hA) && (w[3:0] < 4'hA);
  endfunction

  function automatic tmr_word_t tmr_bcd2bin(input tmr_word_t w);
    int v;
    v = int'(w[15:12]) * 1000 + int'(w[11:8]) * 100 +
        int'(w[7:4]) * 10 + int'(w[3:0]);
    return tmr_word_t'(v);
  endfunction

  // double dabble; callers keep the value at or below 9999
  function automatic tmr_word_t tmr_bin2bcd(input tmr_word_t b);
    logic [31:0] sh;
    sh = {16'h0000, b};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 4; j++) begin
        if (sh[16 + 4 * j +: 4] > 4'h4) begin
          sh[16 + 4 * j +: 4] = sh[16 + 4 * j +: 4] + 4'h3;
        end
      end
      sh = {sh[30:0], 1'b0};
    end
    return sh[31:16];
  endfunction

endpackage

/* hdl/tmr_tick_div.sv */
// time base: 1 ms and 100 ms one-cycle enable pulses
// assumes sys_clk at the rate the package names
`timescale 1ns/100ps

module tmr_tick_div import tmr_pkg::*; #(
  parameter int unsigned MS_CYC = MS_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic ms_tick,
  output logic slow_tick
);

  localparam logic [DIV_W-1:0] MS_LAST = DIV_W'(MS_CYC - 1);
  localparam logic [SLOW_W-1:0] SLOW_LAST = SLOW_W'(SLOW_TICK_MS - 1);

  logic [DIV_W-1:0] div_ff;
  logic [SLOW_W-1:0] slow_ff;

  // R24 millisecond divider
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (div_ff == MS_LAST);
      div_ff <= (div_ff == MS_LAST) ? '0 : div_ff + 1'b1;
    end
  end

  // R24 tenth-second from millisecond ticks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_ff <= '0;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= ms_tick && (slow_ff == SLOW_LAST);
      if (ms_tick) begin
        slow_ff <= (slow_ff == SLOW_LAST) ? '0 : slow_ff + 1'b1;
      end
    end
  end

endmodule

/* hdl/tmr_top.sv */
// millisecond down timer and accumulating tenth-second timer
// assumes all controls come from same-clock scan logic, one exec
// pulse per timer per scan, and a scan no longer than 100 ms
`timescale 1ns/100ps

module tmr_top import tmr_pkg::*; #(
  parameter int unsigned MS_CYC = MS_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire tmr_ctl_s dn_ctl,
  input wire tmr_word_t dn_set_value,
  input wire logic move_op_wr,
  input wire tmr_word_t move_op_data,
  input wire tmr_ctl_s ac_ctl,
  input wire tmr_word_t ac_set_value,
  input wire logic mode_change,
  input wire logic io_memory_hold_bit,
  output tmr_word_t dn_present_value,
  output logic dn_done,
  output logic dn_error_flag,
  output tmr_word_t ac_present_value,
  output logic ac_done,
  output logic ac_error_flag
);

  ////////////////////////////////////////////////////////////////////
  // time base and per-timer elapsed counters

  logic ms_tick;
  logic slow_tick;
  logic [ELAPSED_W-1:0] dn_elapsed;
  logic [ELAPSED_W-1:0] ac_elapsed;

  tmr_tick_div #(.MS_CYC(MS_CYC)) u_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .ms_tick(ms_tick),
    .slow_tick(slow_tick)
  );

  // R22 down timer spends millisecond ticks
  tmr_elapsed u_dn_el (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(ms_tick),
    .take(dn_ctl.exec),
    .count(dn_elapsed)
  );

  // R19 one scan worth of tenth ticks is normally 0 or 1
  tmr_elapsed u_ac_el (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(slow_tick),
    .take(ac_ctl.exec),
    .count(ac_elapsed)
  );

  ////////////////////////////////////////////////////////////////////
  // shared qualifiers

  logic clear_mode;
  logic dn_base;
  logic ac_base;
  logic dn_pend_ff;
  logic dn_in_prev_ff;
  logic ac_pend_ff;

  // R09 hold bit keeps timers across a mode change
  assign clear_mode = mode_change && !io_memory_hold_bit;
  // an execution that no higher-priority event overrides
  assign dn_base = dn_ctl.exec && !clear_mode && !dn_ctl.force_set &&
                   !dn_ctl.force_reset && !dn_ctl.reset_cmd;
  assign ac_base = ac_ctl.exec && !clear_mode && !ac_ctl.force_set &&
                   !ac_ctl.force_reset && !ac_ctl.reset_cmd;

  ////////////////////////////////////////////////////////////////////
  // millisecond down timer

  tmr_word_t dn_cur;
  tmr_word_t dn_rem;
  tmr_word_t dn_cnt;
  tmr_word_t nxt_dn_pv;
  logic nxt_dn_done;

  // R04 R05 remaining time after this scan, in binary then re-encoded
  always_comb begin
    dn_cur = dn_ctl.bcd_mode ? tmr_bcd2bin(dn_present_value)
                             : dn_present_value;
    dn_rem = (dn_cur > {8'h00, dn_elapsed}) ?
             dn_cur - {8'h00, dn_elapsed} : 16'h0000;
    dn_cnt = dn_ctl.bcd_mode ? tmr_bin2bcd(dn_rem) : dn_rem;
  end

  always_comb begin
    nxt_dn_pv = dn_present_value;
    nxt_dn_done = dn_done;
    if (clear_mode) begin
      // R09 mode change clears
      nxt_dn_pv = PV_RESET;
      nxt_dn_done = 1'b0;
    end else if (dn_ctl.force_set) begin
      // R14 forced set
      nxt_dn_pv = PV_RESET;
      nxt_dn_done = 1'b1;
    end else if (dn_ctl.force_reset) begin
      // R14 forced reset
      nxt_dn_pv = dn_set_value;
      nxt_dn_done = 1'b0;
    end else if (dn_ctl.reset_cmd) begin
      // R11 reset command value
      nxt_dn_pv = dn_ctl.bcd_mode ? BCD_FULL : BIN_FULL;
      nxt_dn_done = 1'b0;
    end else if (dn_ctl.exec) begin
      if (dn_ctl.interlock) begin
        // R12 interlock reloads
        nxt_dn_pv = dn_set_value;
        nxt_dn_done = 1'b0;
      end else if (dn_ctl.jump) begin
        // R13 jumped, value and done flag not refreshed
        nxt_dn_pv = dn_present_value;
      end else if (!dn_ctl.timer_in) begin
        // R01 input low reloads
        nxt_dn_pv = dn_set_value;
        nxt_dn_done = 1'b0;
      end else if (dn_pend_ff || !dn_in_prev_ff) begin
        // R11 load set value after command; R02 start of count
        nxt_dn_pv = dn_set_value;
        nxt_dn_done = (dn_set_value == 16'h0000);
      end else begin
        // R02 R03 R07 R08 count down, zero holds and flags done
        nxt_dn_pv = dn_cnt;
        nxt_dn_done = (dn_rem == 16'h0000);
      end
    end else if (move_op_wr) begin
      // R03 a nonzero write relaunches at the next execution
      nxt_dn_pv = move_op_data;
    end
  end

  // R10 power reset leaves zero and done clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dn_present_value <= PV_RESET;
      dn_done <= 1'b0;
    end else begin
      dn_present_value <= nxt_dn_pv;
      dn_done <= nxt_dn_done;
    end
  end

  // input history and pending reload; a jumped scan sees neither
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dn_in_prev_ff <= 1'b0;
      dn_pend_ff <= 1'b0;
    end else if (dn_ctl.reset_cmd) begin
      dn_pend_ff <= 1'b1;
    end else if (dn_base && !dn_ctl.jump) begin
      dn_in_prev_ff <= dn_ctl.timer_in && !dn_ctl.interlock;
      dn_pend_ff <= 1'b0;
    end
  end

  // R06 R25 error only for a BCD set value with a bad digit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dn_error_flag <= 1'b0;
    end else if (dn_ctl.exec) begin
      dn_error_flag <= dn_ctl.bcd_mode && !tmr_bcd_ok(dn_set_value);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // accumulating timer

  tmr_word_t ac_sv_bin;
  tmr_word_t ac_cur;
  logic [16:0] ac_sum;
  tmr_word_t ac_cnt;
  tmr_word_t nxt_ac_pv;
  logic nxt_ac_done;

  // elapsed tenths added in binary, clamped at the set value
  always_comb begin
    ac_sv_bin = ac_ctl.bcd_mode ? tmr_bcd2bin(ac_set_value) : ac_set_value;
    ac_cur = ac_ctl.bcd_mode ? tmr_bcd2bin(ac_present_value)
                             : ac_present_value;
    ac_sum = {1'b0, ac_cur} + {9'h000, ac_elapsed};
    ac_cnt = (ac_sum >= {1'b0, ac_sv_bin}) ? ac_sv_bin : ac_sum[15:0];
  end

  always_comb begin
    nxt_ac_pv = ac_present_value;
    nxt_ac_done = ac_done;
    if (clear_mode) begin
      nxt_ac_pv = PV_RESET;
      nxt_ac_done = 1'b0;
    end else if (ac_ctl.force_set || ac_ctl.force_reset) begin
      // R18 forcing wins over timer and reset inputs
      nxt_ac_pv = PV_RESET;
      nxt_ac_done = ac_ctl.force_set;
    end else if (ac_ctl.reset_cmd) begin
      nxt_ac_pv = ac_ctl.bcd_mode ? BCD_FULL : BIN_FULL;
      nxt_ac_done = 1'b0;
    end else if (ac_ctl.exec && !ac_ctl.interlock && !ac_ctl.jump) begin
      if (ac_ctl.reset_in) begin
        // R16 reset input clears
        nxt_ac_pv = PV_RESET;
        nxt_ac_done = 1'b0;
      end else if (ac_pend_ff) begin
        nxt_ac_pv = ac_set_value;
        nxt_ac_done = 1'b1;
      end else if (ac_ctl.timer_in) begin
        // R15 count up in tenths, done at the set value
        nxt_ac_pv = ac_ctl.bcd_mode ? tmr_bin2bcd(ac_cnt) : ac_cnt;
        nxt_ac_done = (ac_cnt == ac_sv_bin);
      end
    end
  end

  // R10 R17 interlock and jump fall through as a hold
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ac_present_value <= PV_RESET;
      ac_done <= 1'b0;
    end else begin
      ac_present_value <= nxt_ac_pv;
      ac_done <= nxt_ac_done;
    end
  end

  // R11 reload pending after the reset command
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ac_pend_ff <= 1'b0;
    end else if (ac_ctl.reset_cmd) begin
      ac_pend_ff <= 1'b1;
    end else if (ac_base && !ac_ctl.interlock && !ac_ctl.jump) begin
      ac_pend_ff <= 1'b0;
    end
  end

  // R06 R25 accumulator error flag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ac_error_flag <= 1'b0;
    end else if (ac_ctl.exec) begin
      ac_error_flag <= ac_ctl.bcd_mode && !tmr_bcd_ok(ac_set_value);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence dn_run_s;
    dn_base && !dn_ctl.interlock && !dn_ctl.jump && dn_ctl.timer_in &&
    dn_in_prev_ff && !dn_pend_ff && !dn_ctl.bcd_mode;
  endsequence

  sequence dn_stop_s;
    dn_base && !dn_ctl.interlock && !dn_ctl.jump && !dn_ctl.timer_in;
  endsequence

  dn_reload_a: assert property ( // R01
    @(posedge sys_clk) disable iff (!reset_n)
    dn_stop_s |=> dn_present_value == $past(dn_set_value) && !dn_done)
    else $error("down timer did not reload with input low");
  dn_count_a: assert property ( // R02
    @(posedge sys_clk) disable iff (!reset_n)
    dn_run_s |=> dn_present_value <= $past(dn_present_value))
    else $error("down timer value rose while counting");
  dn_flag_a: assert property ( // R07
    @(posedge sys_clk) disable iff (!reset_n)
    dn_run_s |=> dn_done == (dn_present_value == 16'h0000))
    else $error("down timer flag does not match zero value");
  dn_err_a: assert property ( // R06
    @(posedge sys_clk) disable iff (!reset_n)
    dn_ctl.exec |=> dn_error_flag ==
      ($past(dn_ctl.bcd_mode) && !tmr_bcd_ok($past(dn_set_value))))
    else $error("down timer error flag wrong");
  mode_clear_a: assert property ( // R09
    @(posedge sys_clk) disable iff (!reset_n)
    clear_mode |=> dn_present_value == 16'h0000 && !dn_done &&
                   ac_present_value == 16'h0000 && !ac_done)
    else $error("mode change did not clear timers");
  reset_cmd_a: assert property ( // R11
    @(posedge sys_clk) disable iff (!reset_n)
    dn_ctl.reset_cmd && !clear_mode && !dn_ctl.force_set &&
    !dn_ctl.force_reset |=> !dn_done &&
    dn_present_value == ($past(dn_ctl.bcd_mode) ? BCD_FULL : BIN_FULL))
    else $error("reset command value wrong");
  dn_interlock_a: assert property ( // R12
    @(posedge sys_clk) disable iff (!reset_n)
    dn_base && dn_ctl.interlock |=>
      dn_present_value == $past(dn_set_value) && !dn_done)
    else $error("interlocked down timer not reloaded");
  dn_jump_a: assert property ( // R13
    @(posedge sys_clk) disable iff (!reset_n)
    dn_base && dn_ctl.jump && !dn_ctl.interlock |=>
      $stable(dn_present_value) && $stable(dn_done))
    else $error("jumped down timer changed");
  dn_force_a: assert property ( // R14
    @(posedge sys_clk) disable iff (!reset_n)
    dn_ctl.force_set && !clear_mode |=>
      dn_done && dn_present_value == 16'h0000)
    else $error("forced set of down timer wrong");
  ac_count_a: assert property ( // R15
    @(posedge sys_clk) disable iff (!reset_n)
    ac_base && !ac_ctl.interlock && !ac_ctl.jump && !ac_ctl.reset_in &&
    !ac_pend_ff && ac_ctl.timer_in && !ac_ctl.bcd_mode |=>
      ac_present_value >= $past(ac_present_value))
    else $error("accumulator value fell while counting");
  ac_reset_a: assert property ( // R16
    @(posedge sys_clk) disable iff (!reset_n)
    ac_base && !ac_ctl.interlock && !ac_ctl.jump && ac_ctl.reset_in |=>
      ac_present_value == 16'h0000 && !ac_done)
    else $error("accumulator reset input ignored");

  ac_interlock_a: assert property ( // R17
    @(posedge sys_clk) disable iff (!reset_n)
    ac_base && ac_ctl.interlock |=>
      $stable(ac_present_value) && $stable(ac_done))
    else $error("interlocked accumulator changed");

  ac_force_a: assert property ( // R18
    @(posedge sys_clk) disable iff (!reset_n)
    ac_ctl.force_reset && !ac_ctl.force_set && !clear_mode |=>
      ac_present_value == 16'h0000 && !ac_done)
    else $error("forced reset of accumulator wrong");

  tick_gap_a: assert property ( // R24
    @(posedge sys_clk) disable iff (!reset_n)
    ms_tick |=> !ms_tick [*8])
    else $error("millisecond ticks too close");

endmodule

/* test/test_tmr_top.sv */
// self-checking bench for the down timer and accumulating timer
// assumes the timer block with a shortened ms divider; no other parts
`timescale 1ns/100ps

module test_tmr_top import tmr_pkg::*;;
  // 20 cycles per ms tick keeps the 100 ms tick at 2000 cycles
  localparam int unsigned MS_SIM = 20;
  // control masks, same bit order as the control struct
  localparam logic [8:0] EX = 9'h100;
  localparam logic [8:0] TI = 9'h080;
  localparam logic [8:0] BC = 9'h040;
  localparam logic [8:0] FS = 9'h020;
  localparam logic [8:0] FR = 9'h010;
  localparam logic [8:0] IL = 9'h008;
  localparam logic [8:0] JP = 9'h004;
  localparam logic [8:0] RC = 9'h002;
  localparam logic [8:0] RI = 9'h001;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  tmr_ctl_s dn_ctl = '0;
  tmr_ctl_s ac_ctl = '0;
  tmr_word_t dn_set_value = 16'h0005;
  tmr_word_t ac_set_value = 16'h0002;
  tmr_word_t move_op_data = 16'h0000;
  logic move_op_wr = 1'b0;
  logic mode_change = 1'b0;
  logic io_memory_hold_bit = 1'b0;
  tmr_word_t dn_present_value;
  tmr_word_t ac_present_value;
  logic dn_done;
  logic dn_error_flag;
  logic ac_done;
  logic ac_error_flag;
  int n_errors = 0;
  int n_compared = 0;

  ////////////////////////////////////////////////////////////////////////
  // clock and design

  // 50 MHz
  always #10 sys_clk = ~sys_clk;

  tmr_top #(.MS_CYC(MS_SIM)) DUT (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .dn_ctl(dn_ctl),
    .dn_set_value(dn_set_value),
    .move_op_wr(move_op_wr),
    .move_op_data(move_op_data),
    .ac_ctl(ac_ctl),
    .ac_set_value(ac_set_value),
    .mode_change(mode_change),
    .io_memory_hold_bit(io_memory_hold_bit),
    .dn_present_value(dn_present_value),
    .dn_done(dn_done),
    .dn_error_flag(dn_error_flag),
    .ac_present_value(ac_present_value),
    .ac_done(ac_done),
    .ac_error_flag(ac_error_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // compare and drive tasks; all drivers start and end on a falling edge

  task automatic chk_word(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (exp !== got) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_dn(input logic [15:0] pv, input logic done);
    chk_word("dn_present_value", pv, dn_present_value);
    chk_bit("dn_done", done, dn_done);
  endtask

  task automatic chk_ac(input logic [15:0] pv, input logic done);
    chk_word("ac_present_value", pv, ac_present_value);
    chk_bit("ac_done", done, ac_done);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one-cycle command, then one more cycle for the answer to land;
  // timer input and number form stay as levels afterwards
  task automatic pulse(input logic ac, input logic [8:0] b);
    if (ac) ac_ctl = tmr_ctl_s'(b);
    else dn_ctl = tmr_ctl_s'(b);
    @(negedge sys_clk);
    if (ac) ac_ctl = tmr_ctl_s'(b & (TI | BC));
    else dn_ctl = tmr_ctl_s'(b & (TI | BC));
    @(negedge sys_clk);
  endtask

  task automatic move_wr(input logic [15:0] d);
    move_op_data = d;
    move_op_wr = 1'b1;
    @(negedge sys_clk);
    move_op_wr = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic mode_pulse(input logic hold);
    io_memory_hold_bit = hold;
    mode_change = 1'b1;
    @(negedge sys_clk);
    mode_change = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard: far above the planned run of about 6300 cycles
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence

  initial begin
    wait_cyc(4);
    chk_dn(16'h0000, 1'b0);
    chk_ac(16'h0000, 1'b0);
    reset_n = 1'b1;
    wait_cyc(2);
    // one slot per timer, set values legal but error cases
    // down timer, 5 ms binary; execs spaced 40 cycles = 2 ms each
    // binary form so the counting checks in the design get exercised
    pulse(0, EX);
    chk_dn(16'h0005, 1'b0);
    pulse(0, EX | TI);
    chk_dn(16'h0005, 1'b0);
    wait_cyc(38);
    pulse(0, EX | TI);
    chk_dn(16'h0003, 1'b0);
    wait_cyc(38);
    pulse(0, EX | TI);
    chk_dn(16'h0001, 1'b0);
    wait_cyc(38);
    pulse(0, EX | TI);
    chk_dn(16'h0000, 1'b1);
    wait_cyc(38);
    pulse(0, EX | TI);
    chk_dn(16'h0000, 1'b1);
    pulse(0, EX | TI | BC | JP);
    chk_dn(16'h0000, 1'b1);
    move_wr(16'h0004);
    chk_word("dn_present_value", 16'h0004, dn_present_value);
    pulse(0, EX | TI | BC | IL);
    chk_dn(16'h0005, 1'b0);
    // forcing acts without an exec
    pulse(0, BC | FS);
    chk_dn(16'h0000, 1'b1);
    pulse(0, BC | FR);
    chk_dn(16'h0005, 1'b0);
    mode_pulse(1'b1);
    chk_dn(16'h0005, 1'b0);
    mode_pulse(1'b0);
    chk_dn(16'h0000, 1'b0);
    pulse(0, BC | RC);
    chk_dn(16'h9999, 1'b0);
    pulse(0, EX | BC);
    chk_dn(16'h0005, 1'b0);
    // a digit above nine is only an error in BCD form
    dn_set_value = 16'h00A5;
    pulse(0, EX | BC);
    chk_bit("dn_error_flag", 1'b1, dn_error_flag);
    pulse(0, EX);
    chk_bit("dn_error_flag", 1'b0, dn_error_flag);
    chk_word("dn_present_value", 16'h00A5, dn_present_value);
    dn_set_value = 16'hFFFF;
    pulse(0, EX);
    chk_word("dn_present_value", 16'hFFFF, dn_present_value);
    dn_set_value = 16'h1234;
    pulse(0, RC);
    chk_dn(16'hFFFF, 1'b0);
    pulse(0, EX);
    chk_dn(16'h1234, 1'b0);
    dn_set_value = 16'h9999;
    pulse(0, EX | BC);
    chk_word("dn_present_value", 16'h9999, dn_present_value);
    chk_bit("dn_error_flag", 1'b0, dn_error_flag);
    // BCD ten less two ms must read 08, a binary slip would show 0E
    dn_set_value = 16'h0010;
    pulse(0, EX | BC);
    chk_dn(16'h0010, 1'b0);
    pulse(0, EX | TI | BC);
    wait_cyc(38);
    pulse(0, EX | TI | BC);
    chk_dn(16'h0008, 1'b0);
    // accumulating timer, set 0.2 s; execs spaced one 100 ms tick
    pulse(1, EX | RI);
    chk_ac(16'h0000, 1'b0);
    wait_cyc(1998);
    pulse(1, EX | TI);
    chk_ac(16'h0001, 1'b0);
    wait_cyc(1998);
    pulse(1, EX);
    chk_ac(16'h0001, 1'b0);
    wait_cyc(1998);
    pulse(1, EX | TI);
    chk_ac(16'h0002, 1'b1);
    pulse(1, EX | TI | BC | IL);
    chk_ac(16'h0002, 1'b1);
    // forcing wins over both timer and reset inputs
    pulse(1, TI | BC | RI | FS);
    chk_ac(16'h0000, 1'b1);
    pulse(1, TI | BC | FR);
    chk_ac(16'h0000, 1'b0);
    ac_set_value = 16'hB000;
    pulse(1, EX | BC | RI);
    chk_bit("ac_error_flag", 1'b1, ac_error_flag);
    pulse(1, EX | RI);
    chk_bit("ac_error_flag", 1'b0, ac_error_flag);
    ac_set_value = 16'h0002;
    pulse(1, BC | RC);
    chk_ac(16'h9999, 1'b0);
    pulse(1, EX | BC);
    chk_ac(16'h0002, 1'b1);
    mode_pulse(1'b0);
    chk_ac(16'h0000, 1'b0);
    // second reset in mid-run, checked while it is held
    dn_set_value = 16'h0005;
    pulse(0, EX | BC);
    reset_n = 1'b0;
    #1;
    chk_dn(16'h0000, 1'b0);
    chk_ac(16'h0000, 1'b0);
    print_verdict();
  end
endmodule
